// ---- inc/ppc_consts.svh ----
// register offsets, field positions, reset values and codes of the port power pad block
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// register offsets on the register port
`define PPC_OFS_IND_PULLUP 16'h083F
`define PPC_OFS_PAD_PULLDOWN 16'h092E
`define PPC_OFS_PAD_DIR 16'h0932
`define PPC_OFS_PAD_OUT 16'h0936
`define PPC_OFS_PAD_IN 16'h093A
`define PPC_OFS_PAD_PULLUP 16'h093E
`define PPC_OFS_PORT1_SEL 16'h3C00
`define PPC_OFS_PORT1_STATUS 16'h3C40

// field positions
`define PPC_IND_PULLUP_BIT 0
`define PPC_SEL_SHARED_BIT 7
`define PPC_SEL_RSVD_BIT 6
`define PPC_SEL_DISABLE_BIT 5
`define PPC_SEL_FIXED_BIT 4
`define PPC_SEL_SRC_MSB 3
`define PPC_SEL_SRC_LSB 0
`define PPC_STAT_POWER_BIT 0
`define PPC_STAT_OC_BIT 1
`define PPC_STAT_RSVD_SRC_BIT 2
`define PPC_STAT_DISABLED_BIT 3

// masks of bits that keep a value; read-only reserved bits are cleared
`define PPC_MASK_PAD_PULLUP 8'hFE
`define PPC_MASK_PORT1_SEL 8'hBF

// reset values
`define PPC_RST_IND_PULLUP 8'h00
`define PPC_RST_PAD_PULLDOWN 8'h00
`define PPC_RST_PAD_DIR 8'h00
`define PPC_RST_PAD_OUT 8'h00
`define PPC_RST_PAD_PULLUP 8'h00
`define PPC_RST_PORT1_SEL 8'h00

// power source codes
`define PPC_SRC_OFF 4'h0
`define PPC_SRC_USB2 4'h1
`define PPC_SRC_USB3 4'h2
`define PPC_SRC_EITHER 4'h3
`define PPC_SRC_GPIO 4'h4

`endif

// ---- inc/ppc_pkg.sv ----
// types shared by the port power pad block
package ppc_pkg;
    typedef logic [15:0] ppc_addr_t;
    typedef logic [7:0] ppc_byte_t;
    typedef logic [3:0] ppc_src_code_t;
    typedef enum logic [2:0] {
        PPC_SRC_IS_OFF,
        PPC_SRC_IS_USB2,
        PPC_SRC_IS_USB3,
        PPC_SRC_IS_EITHER,
        PPC_SRC_IS_GPIO,
        PPC_SRC_IS_RSVD
    } ppc_src_e;
endpackage : ppc_pkg

// ---- rtl/ppc_pad_cell.sv ----
// one port power pad: registered drive, enable and input sample
module ppc_pad_cell (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // configuration
    input wire logic dir_out,
    input wire logic out_value,
    // pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    // sampled level
    output logic in_sample
);
    // drive value and enable follow the configuration one edge later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else if (clk_en) begin
            pad_out <= out_value;
            pad_oe <= dir_out;
        end
    end

    // input buffer sampled every enabled cycle, also while driving, so software sees the pad
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_sample <= 1'b0;
        end else if (clk_en) begin
            in_sample <= pad_in;
        end
    end
endmodule : ppc_pad_cell

// ---- rtl/ppc_power_source.sv ----
// port power switch: decodes the source field and registers the power enable
`include "ppc_consts.svh"
module ppc_power_source (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // configuration
    input wire ppc_pkg::ppc_src_code_t src_code,
    input wire logic port_disabled,
    // power requests
    input wire logic usb2_power,
    input wire logic usb3_power,
    input wire logic gp_level,
    // result
    output logic power_on,
    output logic src_reserved
);
    import ppc_pkg::*;

    ppc_src_e src_kind;
    logic next_power_on;

    // map the code onto a source kind
    always_comb begin
        case (src_code)
            `PPC_SRC_OFF: src_kind = PPC_SRC_IS_OFF;
            `PPC_SRC_USB2: src_kind = PPC_SRC_IS_USB2;
            `PPC_SRC_USB3: src_kind = PPC_SRC_IS_USB3;
            `PPC_SRC_EITHER: src_kind = PPC_SRC_IS_EITHER;
            `PPC_SRC_GPIO: src_kind = PPC_SRC_IS_GPIO;
            default: src_kind = PPC_SRC_IS_RSVD;
        endcase
    end

    // a reserved code keeps power off rather than guessing a source
    always_comb begin
        case (src_kind)
            PPC_SRC_IS_USB2: next_power_on = usb2_power;
            PPC_SRC_IS_USB3: next_power_on = usb3_power;
            PPC_SRC_IS_EITHER: next_power_on = usb2_power | usb3_power;
            PPC_SRC_IS_GPIO: next_power_on = gp_level;
            default: next_power_on = 1'b0;
        endcase
        if (port_disabled) begin
            next_power_on = 1'b0;
        end
    end

    // registered so the switch pin never glitches on a source change
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_on <= 1'b0;
            src_reserved <= 1'b0;
        end else if (clk_en) begin
            power_on <= next_power_on;
            src_reserved <= (src_kind == PPC_SRC_IS_RSVD);
        end
    end
endmodule : ppc_power_source

// ---- rtl/ppc_port_power_pad_ctrl.sv ----
// register file and pad control for the port power pads, indicator pull-up and port 1 select
//
// Our own choice: strobed register access.
`include "ppc_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - indicator pin pull-up follows bit 0
// - pull-down bits 7:1 drive pad pull-downs
// - direction bits 7:1: 0 in, 1 out
// - output bits 7:1 drive output pads
// - input register returns sampled pad levels
// - pull-up bits 7:1 drive pad pull-ups
// - port 1 bit 7 selects shared pin
// - port 1 bit 5 disables port while set
// - port 1 bit 4 flags fixed device
// - port 1 bits 3:0 choose power source
////////////////////////////////////////////////////////////////////////////////
module ppc_port_power_pad_ctrl #(
    parameter int NUM_PADS = 7,
    parameter bit OC_ACTIVE_LOW = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire ppc_pkg::ppc_addr_t reg_addr,
    input wire ppc_pkg::ppc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ppc_pkg::ppc_byte_t reg_rdata,
    // indicator pin
    output logic indicator_pin_pullup_en,
    // port power pads
    input wire logic [NUM_PADS:1] port_power_pad_in,
    output logic [NUM_PADS:1] port_power_pad_out,
    output logic [NUM_PADS:1] port_power_pad_oe,
    output logic [NUM_PADS:1] port_power_pad_pullup_en,
    output logic [NUM_PADS:1] port_power_pad_pulldown_en,
    // port 1 power requests and over-current sense
    input wire logic usb2_port_power,
    input wire logic usb3_port_power,
    input wire logic general_purpose_pin,
    input wire logic port1_oc_sense_in,
    // port 1 status towards the hub
    output logic port1_power_on,
    output logic port1_oc_detect,
    output logic port1_shared_pin,
    output logic port1_disabled,
    output logic port1_fixed_attach
);
    import ppc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    ppc_byte_t indicator_pin_pullup_ctrl;
    ppc_byte_t power_pad_pulldown_ctrl;
    ppc_byte_t power_pad_direction;
    ppc_byte_t power_pad_output_value;
    ppc_byte_t power_pad_pullup_ctrl;
    ppc_byte_t downstream_port1_power_source;

    // write strobes decoded per register
    logic wr_ind_pullup;
    logic wr_pad_pulldown;
    logic wr_pad_dir;
    logic wr_pad_out;
    logic wr_pad_pullup;
    logic wr_port1_sel;

    // state shown back to software
    logic [NUM_PADS:1] pad_in_sample;
    ppc_byte_t power_pad_input_value;
    ppc_byte_t port1_status;
    logic port1_src_reserved;
    logic oc_pin_q;
    logic oc_level;

    ppc_byte_t next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // write decode

    // a write to the read-only input or status register matches nothing here
    always_comb begin
        wr_ind_pullup = reg_wr && (reg_addr == `PPC_OFS_IND_PULLUP);
        wr_pad_pulldown = reg_wr && (reg_addr == `PPC_OFS_PAD_PULLDOWN);
        wr_pad_dir = reg_wr && (reg_addr == `PPC_OFS_PAD_DIR);
        wr_pad_out = reg_wr && (reg_addr == `PPC_OFS_PAD_OUT);
        wr_pad_pullup = reg_wr && (reg_addr == `PPC_OFS_PAD_PULLUP);
        wr_port1_sel = reg_wr && (reg_addr == `PPC_OFS_PORT1_SEL);
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    // indicator pull-up; bits 7:1 are writable spares with no pin behind them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            indicator_pin_pullup_ctrl <= `PPC_RST_IND_PULLUP;
        end else if (clk_en && wr_ind_pullup) begin
            indicator_pin_pullup_ctrl <= reg_wdata;
        end
    end

    // pad pull-downs; bit 0 is a writable spare
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_pad_pulldown_ctrl <= `PPC_RST_PAD_PULLDOWN;
        end else if (clk_en && wr_pad_pulldown) begin
            power_pad_pulldown_ctrl <= reg_wdata;
        end
    end

    // pad directions; bit 0 is a writable spare
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_pad_direction <= `PPC_RST_PAD_DIR;
        end else if (clk_en && wr_pad_dir) begin
            power_pad_direction <= reg_wdata;
        end
    end

    // pad output data; bit 0 is a writable spare
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_pad_output_value <= `PPC_RST_PAD_OUT;
        end else if (clk_en && wr_pad_out) begin
            power_pad_output_value <= reg_wdata;
        end
    end

    // pad pull-ups; bit 0 is read-only and held at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_pad_pullup_ctrl <= `PPC_RST_PAD_PULLUP;
        end else if (clk_en && wr_pad_pullup) begin
            power_pad_pullup_ctrl <= reg_wdata & `PPC_MASK_PAD_PULLUP;
        end
    end

    // port 1 select; bit 6 is read-only and held at zero.
    // the block accepts a write at any time and acts on it at once: keeping it
    // static while the hub runs is up to whoever loads the configuration
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            downstream_port1_power_source <= `PPC_RST_PORT1_SEL;
        end else if (clk_en && wr_port1_sel) begin
            downstream_port1_power_source <= reg_wdata & `PPC_MASK_PORT1_SEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad cells

    // one cell per pad; pad N is controlled by bit N of each register
    for (genvar n = 1; n <= NUM_PADS; n++) begin : g_pad
        ppc_pad_cell u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .dir_out(power_pad_direction[n]),
            .out_value(power_pad_output_value[n]),
            .pad_in(port_power_pad_in[n]),
            .pad_out(port_power_pad_out[n]),
            .pad_oe(port_power_pad_oe[n]),
            .in_sample(pad_in_sample[n])
        );
    end

    // resistor enables come straight from the register flops
    always_comb begin
        port_power_pad_pulldown_en = power_pad_pulldown_ctrl[NUM_PADS:1];
        port_power_pad_pullup_en = power_pad_pullup_ctrl[NUM_PADS:1];
        indicator_pin_pullup_en = indicator_pin_pullup_ctrl[`PPC_IND_PULLUP_BIT];
    end

    // input register view: sampled pads above a reserved zero bit 0
    always_comb begin
        power_pad_input_value = '0;
        power_pad_input_value[NUM_PADS:1] = pad_in_sample;
    end

    ////////////////////////////////////////////////////////////////////////////
    // port 1 power and sense

    // the source field picks what switches port 1 power
    ppc_power_source u_source (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .src_code(downstream_port1_power_source[`PPC_SEL_SRC_MSB:`PPC_SEL_SRC_LSB]),
        .port_disabled(downstream_port1_power_source[`PPC_SEL_DISABLE_BIT]),
        .usb2_power(usb2_port_power),
        .usb3_power(usb3_port_power),
        .gp_level(general_purpose_pin),
        .power_on(port1_power_on),
        .src_reserved(port1_src_reserved)
    );

    // separate sense pin sampled once so both paths carry equal delay
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_pin_q <= 1'b0;
        end else if (clk_en) begin
            oc_pin_q <= port1_oc_sense_in;
        end
    end

    // in shared mode the fault is read from pad 1 itself
    always_comb begin
        if (downstream_port1_power_source[`PPC_SEL_SHARED_BIT]) begin
            oc_level = pad_in_sample[1];
        end else begin
            oc_level = oc_pin_q;
        end
    end

    // port 1 flags towards the hub; a disabled port never reports a fault
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port1_oc_detect <= 1'b0;
            port1_shared_pin <= 1'b0;
            port1_disabled <= 1'b0;
            port1_fixed_attach <= 1'b0;
        end else if (clk_en) begin
            port1_shared_pin <= downstream_port1_power_source[`PPC_SEL_SHARED_BIT];
            port1_disabled <= downstream_port1_power_source[`PPC_SEL_DISABLE_BIT];
            port1_fixed_attach <= downstream_port1_power_source[`PPC_SEL_FIXED_BIT];
            port1_oc_detect <= (oc_level ^ OC_ACTIVE_LOW)
                && !downstream_port1_power_source[`PPC_SEL_DISABLE_BIT];
        end
    end

    // status view of what port 1 is really doing
    always_comb begin
        port1_status = '0;
        port1_status[`PPC_STAT_POWER_BIT] = port1_power_on;
        port1_status[`PPC_STAT_OC_BIT] = port1_oc_detect;
        port1_status[`PPC_STAT_RSVD_SRC_BIT] = port1_src_reserved;
        port1_status[`PPC_STAT_DISABLED_BIT] = port1_disabled;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    // unmapped offsets read as zero
    always_comb begin
        case (reg_addr)
            `PPC_OFS_IND_PULLUP: next_rdata = indicator_pin_pullup_ctrl;
            `PPC_OFS_PAD_PULLDOWN: next_rdata = power_pad_pulldown_ctrl;
            `PPC_OFS_PAD_DIR: next_rdata = power_pad_direction;
            `PPC_OFS_PAD_OUT: next_rdata = power_pad_output_value;
            `PPC_OFS_PAD_IN: next_rdata = power_pad_input_value;
            `PPC_OFS_PAD_PULLUP: next_rdata = power_pad_pullup_ctrl;
            `PPC_OFS_PORT1_SEL: next_rdata = downstream_port1_power_source;
            `PPC_OFS_PORT1_STATUS: next_rdata = port1_status;
            default: next_rdata = '0;
        endcase
    end

    // data stand in the cycle after an enabled strobe, zero after other enabled cycles; frozen cycles hold them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end else begin
                reg_rdata <= '0;
            end
        end
    end
endmodule : ppc_port_power_pad_ctrl

// ---- verification/ppc_port_power_pad_ctrl_monitor.sv ----
// concurrent checks on the port power pad block ports
`include "ppc_consts.svh"
module ppc_port_power_pad_ctrl_monitor #(
    parameter int NUM_PADS = 7,
    parameter bit OC_ACTIVE_LOW = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire ppc_pkg::ppc_addr_t reg_addr,
    input wire ppc_pkg::ppc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire ppc_pkg::ppc_byte_t reg_rdata,
    // pins
    input wire logic indicator_pin_pullup_en,
    input wire logic [NUM_PADS:1] port_power_pad_in,
    input wire logic [NUM_PADS:1] port_power_pad_out,
    input wire logic [NUM_PADS:1] port_power_pad_oe,
    input wire logic [NUM_PADS:1] port_power_pad_pullup_en,
    input wire logic [NUM_PADS:1] port_power_pad_pulldown_en,
    // port 1 status
    input wire logic port1_power_on,
    input wire logic port1_disabled
);
    import ppc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // accepted write strobe; frozen cycles take nothing
    logic wr_ok;
    assign wr_ok = clk_en && reg_wr;

    chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd)
        |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_pullup_copy: assert property (wr_ok && reg_addr == `PPC_OFS_PAD_PULLUP
        |=> port_power_pad_pullup_en == $past(reg_wdata[NUM_PADS:1]))
        else $error("pad pull-ups do not follow the written bits");
    chk_pulldown_copy: assert property (wr_ok && reg_addr == `PPC_OFS_PAD_PULLDOWN
        |=> port_power_pad_pulldown_en == $past(reg_wdata[NUM_PADS:1]))
        else $error("pad pull-downs do not follow the written bits");
    chk_indicator_copy: assert property (wr_ok && reg_addr == `PPC_OFS_IND_PULLUP
        |=> indicator_pin_pullup_en == $past(reg_wdata[0]))
        else $error("indicator pull-up does not follow bit 0");
    chk_dir_to_oe: assert property (wr_ok && reg_addr == `PPC_OFS_PAD_DIR ##1 clk_en
        |=> port_power_pad_oe == $past(reg_wdata[NUM_PADS:1], 2))
        else $error("pad drive enables do not follow direction bits");
    chk_out_drive: assert property (wr_ok && reg_addr == `PPC_OFS_PAD_OUT ##1 clk_en
        |=> (port_power_pad_out & port_power_pad_oe)
            == ($past(reg_wdata[NUM_PADS:1], 2) & port_power_pad_oe))
        else $error("driven pad level differs from output bits");
    // the sample flop must have left reset before the read edge
    chk_pad_sample: assert property (clk_en && reg_rd && reg_addr == `PPC_OFS_PAD_IN
        && $past(clk_en) && $past(rst_b) |=> reg_rdata == {$past(port_power_pad_in, 2), 1'b0})
        else $error("input register differs from sampled pads");
    chk_disabled_off: assert property (port1_disabled && $past(port1_disabled)
        |-> !port1_power_on)
        else $error("disabled port 1 still powered");

    cov_sel_write: cover property (wr_ok && reg_addr == `PPC_OFS_PORT1_SEL);
    cov_pad_read: cover property (reg_rd && reg_addr == `PPC_OFS_PAD_IN);
    cov_power_on: cover property ($rose(port1_power_on));
endmodule : ppc_port_power_pad_ctrl_monitor
////////////////////////////////////////////////////////////////////////////////
bind ppc_port_power_pad_ctrl ppc_port_power_pad_ctrl_monitor #(
    .NUM_PADS(NUM_PADS), .OC_ACTIVE_LOW(OC_ACTIVE_LOW)) u_ppc_port_power_pad_ctrl_monitor (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .indicator_pin_pullup_en(indicator_pin_pullup_en), .port_power_pad_in(port_power_pad_in),
    .port_power_pad_out(port_power_pad_out), .port_power_pad_oe(port_power_pad_oe),
    .port_power_pad_pullup_en(port_power_pad_pullup_en),
    .port_power_pad_pulldown_en(port_power_pad_pulldown_en),
    .port1_power_on(port1_power_on), .port1_disabled(port1_disabled));

// ---- verification/ppc_pad_world_model.sv ----
// model of the pads' outside world: board drive, pulls and the power switch sense
module ppc_pad_world_model #(
    parameter int NUM_PADS = 7
) (
    // clock
    input wire logic clk,
    // pad control and port 1 power from the block
    input wire logic [NUM_PADS:1] pad_out,
    input wire logic [NUM_PADS:1] pad_oe,
    input wire logic [NUM_PADS:1] pullup_en,
    input wire logic [NUM_PADS:1] pulldown_en,
    input wire logic power_on,
    // board drive and fault commanded by the bench
    input wire logic [NUM_PADS:1] ext_en,
    input wire logic [NUM_PADS:1] ext_val,
    input wire logic fault,
    // levels back into the block
    output logic [NUM_PADS:1] pad_in,
    output logic oc_sense_b
);
    logic [NUM_PADS:1] float_lvl = '0;
    // a floating pad flips every cycle so a read of it never matches by luck
    always @(posedge clk) begin
        float_lvl <= ~float_lvl;
    end
    // wire level: block drive wins, then board drive, then the pulls
    always_comb begin
        for (int n = 1; n <= NUM_PADS; n++) begin
            if (pad_oe[n]) pad_in[n] = pad_out[n];
            else if (ext_en[n]) pad_in[n] = ext_val[n];
            else if (pullup_en[n]) pad_in[n] = 1'b1;
            else if (pulldown_en[n]) pad_in[n] = 1'b0;
            else pad_in[n] = float_lvl[n];
        end
    end
    // the switch flags over-current, active low, only while it carries power
    assign oc_sense_b = !(fault && power_on);
endmodule : ppc_pad_world_model

// ---- verification/tb_top.sv ----
// self-checking bench of the port power pad block
`include "ppc_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    ppc_addr_t reg_addr = '0;
    ppc_byte_t reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic usb2 = 1'b0;
    logic usb3 = 1'b0;
    logic gp = 1'b0;
    logic fault = 1'b0;
    logic [7:1] ext_en = '1;
    logic [7:1] ext_val = '0;
    ppc_byte_t reg_rdata;
    logic [7:1] pad_in, pad_out, pad_oe, pad_pu, pad_pd;
    logic ind_pu, oc_b, p1_on, p1_oc, p1_sh, p1_dis, p1_fix;
    int mismatches = 0;
    int num_checks = 0;
    ppc_byte_t exp_q[$];
    logic pend = 1'b0;

    always #2 clk = ~clk;

    ppc_port_power_pad_ctrl u_ppc_port_power_pad_ctrl (.clk(clk), .rst_b(rst_b),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .indicator_pin_pullup_en(ind_pu),
        .port_power_pad_in(pad_in), .port_power_pad_out(pad_out), .port_power_pad_oe(pad_oe),
        .port_power_pad_pullup_en(pad_pu), .port_power_pad_pulldown_en(pad_pd),
        .usb2_port_power(usb2), .usb3_port_power(usb3), .general_purpose_pin(gp),
        .port1_oc_sense_in(oc_b), .port1_power_on(p1_on), .port1_oc_detect(p1_oc),
        .port1_shared_pin(p1_sh), .port1_disabled(p1_dis), .port1_fixed_attach(p1_fix));
    ppc_pad_world_model u_ppc_pad_world_model (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_en(pad_pu), .pulldown_en(pad_pd), .power_on(p1_on), .ext_en(ext_en),
        .ext_val(ext_val), .fault(fault), .pad_in(pad_in), .oc_sense_b(oc_b));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // one bus cycle; strobes are set once per edge so back-to-back is safe
    task automatic bus(input logic w, input logic r, input ppc_addr_t a, input ppc_byte_t d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic wr(input ppc_addr_t a, input ppc_byte_t d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input ppc_addr_t a, input ppc_byte_t e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    function automatic logic pwr(input logic [3:0] c, input logic [2:0] k);
        case (c)
            `PPC_SRC_USB2: return k[0];
            `PPC_SRC_USB3: return k[1];
            `PPC_SRC_EITHER: return k[0] | k[1];
            `PPC_SRC_GPIO: return k[2];
            default: return 1'b0;
        endcase
    endfunction : pwr
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // read answers land in the cycle after the strobe; oldest note first
    always @(posedge clk) begin
        if (pend && exp_q.size() == 0) begin
            mismatches++;
            $display("[ERR] %0t read answer with no expectation", $time);
        end else if (pend) begin
            check(reg_rdata, exp_q.pop_front(), "read data");
        end
        pend = rst_b && reg_rd;
    end

    // hang guard
    initial begin
        repeat (50000) @(posedge clk);
        mismatches++;
        $display("[ERR] %0t run did not end", $time);
        finish_test();
    end

    initial begin
        ppc_byte_t d, dir, outv, pu, en, ev;
        logic [7:1] lvl;
        void'($urandom(59206));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // every register but the port 1 status register, and an unmapped place, read zero
        rd(`PPC_OFS_IND_PULLUP, 8'h00);
        rd(`PPC_OFS_PAD_PULLDOWN, 8'h00);
        rd(`PPC_OFS_PAD_DIR, 8'h00);
        rd(`PPC_OFS_PAD_OUT, 8'h00);
        rd(`PPC_OFS_PAD_IN, 8'h00);
        rd(`PPC_OFS_PAD_PULLUP, 8'h00);
        rd(`PPC_OFS_PORT1_SEL, 8'h00);
        rd(16'h0200, 8'h00);
        idle(2);
        check({pad_pu, ind_pu}, 8'h00, "pull-ups after reset");
        check({pad_oe, 1'b0}, 8'h00, "drive after reset");
        $display("test reset_values done");
        // read-back with reserved bits; refused writes vanish
        for (int i = 0; i < 4; i++) begin
            d = ppc_byte_t'($urandom);
            wr(`PPC_OFS_IND_PULLUP, d);
            wr(`PPC_OFS_PAD_PULLDOWN, d ^ 8'h5A);
            wr(`PPC_OFS_PAD_PULLUP, ~d);
            wr(16'h0200, d);
            rd(`PPC_OFS_IND_PULLUP, d);
            rd(`PPC_OFS_PAD_PULLDOWN, d ^ 8'h5A);
            rd(`PPC_OFS_PAD_PULLUP, ~d & 8'hFE);
            rd(16'h0200, 8'h00);
            idle(1);
            check({pad_pu, ind_pu}, {~d[7:1], d[0]}, "pull-up pins");
            check({pad_pd, 1'b0}, (d ^ 8'h5A) & 8'hFE, "pull-down pins");
        end
        $display("test register_access done");
        // random direction, drive, board level and pulls
        for (int i = 0; i < 8; i++) begin
            dir = ppc_byte_t'($urandom);
            outv = ppc_byte_t'($urandom);
            pu = ppc_byte_t'($urandom);
            en = ppc_byte_t'($urandom);
            ev = ppc_byte_t'($urandom);
            ext_en <= en[7:1];
            ext_val <= ev[7:1];
            wr(`PPC_OFS_PAD_PULLUP, pu);
            wr(`PPC_OFS_PAD_PULLDOWN, ~pu);
            wr(`PPC_OFS_PAD_DIR, dir);
            wr(`PPC_OFS_PAD_OUT, outv);
            wr(`PPC_OFS_PAD_IN, 8'hFF);
            idle(3);
            lvl = dir[7:1] & outv[7:1] | ~dir[7:1] & (en[7:1] & ev[7:1] | ~en[7:1] & pu[7:1]);
            check({pad_oe, 1'b0}, dir & 8'hFE, "pad drive enables");
            check({pad_out & pad_oe, 1'b0}, dir & outv & 8'hFE, "pad drive levels");
            rd(`PPC_OFS_PAD_IN, {lvl, 1'b0});
            rd(`PPC_OFS_PAD_DIR, dir);
            rd(`PPC_OFS_PAD_OUT, outv);
        end
        $display("test pad_levels done");
        // every source code against every request combination
        for (int c = 0; c < 16; c++) begin
            wr(`PPC_OFS_PORT1_SEL, {4'h0, 4'(c)});
            rd(`PPC_OFS_PORT1_SEL, {4'h0, 4'(c)});
            for (int k = 0; k < 8; k++) begin
                usb2 <= k[0];
                usb3 <= k[1];
                gp <= k[2];
                idle(3);
                check({7'h00, p1_on}, {7'h00, pwr(4'(c), 3'(k))}, "port 1 power");
            end
        end
        $display("test power_source done");
        // flags, bit 6 refused, disable overrides a powered source
        usb2 <= 1'b1;
        wr(`PPC_OFS_PORT1_SEL, 8'hF1);
        rd(`PPC_OFS_PORT1_SEL, 8'hB1);
        idle(3);
        check({4'h0, p1_on, p1_sh, p1_dis, p1_fix}, 8'h07, "port 1 flags");
        wr(`PPC_OFS_PORT1_SEL, 8'h01);
        fault <= 1'b1;
        idle(4);
        check({3'h0, p1_oc, p1_on, p1_sh, p1_dis, p1_fix}, 8'h18, "separate sense");
        rd(`PPC_OFS_PORT1_STATUS, 8'h03);
        // shared pin: fault taken from pad 1, sense pin ignored
        wr(`PPC_OFS_PAD_DIR, 8'h00);
        clk_en <= 1'b0;
        wr(`PPC_OFS_PAD_DIR, 8'hFF);
        clk_en <= 1'b1;
        rd(`PPC_OFS_PAD_DIR, 8'h00);
        wr(`PPC_OFS_PORT1_SEL, 8'h81);
        ext_en <= '1;
        ext_val <= '1;
        idle(4);
        check({6'h00, p1_oc, p1_sh}, 8'h01, "shared pin high");
        ext_val <= '0;
        idle(4);
        check({6'h00, p1_oc, p1_sh}, 8'h03, "shared pin low");
        fault <= 1'b0;
        $display("test port1_flags done");
        finish_test();
    end
endmodule : tb_top
